// File: rtl/irqen_ctrl.sv
// Purpose: Interrupt enable gating, source flags and idle/power-down control.
// Assumes: Timer and serial inputs come from clk_sys logic; pins are async.
// Notes:   Registers reached over APB; zero wait states.
`timescale 1ns/100ps
module irqen_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        externalIrqPinA_n,
  input  wire logic        externalIrqPinB_n,
  input  wire logic        timer2TriggerPin,
  input  wire logic        hwResetPin,
  input  wire logic        timer0Ovf,
  input  wire logic        timer1Ovf,
  input  wire logic        timer2Ovf,
  input  wire logic        serialReq,
  input  wire logic        extProgMem,
  input  wire logic        coreAck,
  input  wire logic        coreAddrLatch,
  input  wire logic        coreProgStrobe,
  output logic             irqRequest,
  output logic      [2:0]  irqVector,
  output logic             coreRun,
  output logic             oscRun,
  output logic             ramBlock,
  output logic             coreResetOut,
  output logic             addrLatchStrobe,
  output logic             progStoreStrobe,
  output logic             port0Float,
  output logic             port2AddrDrive
);

  irqen_timing_if tim ();
  irqen_pkg::irqen_mode_t state_q;
  irqen_pkg::irqen_mode_t state_d;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [3:0]  pinPrev_q;
  logic [7:0]  enable_q;
  logic [7:0]  enable_d;
  logic [6:0]  flags_q;
  logic [6:0]  flags_d;
  logic [3:0]  ctrl_q;
  logic [3:0]  ctrl_d;
  logic        pendT0_q;
  logic        pendT0_d;
  logic        pendT1_q;
  logic        pendT1_d;
  logic        pendT2_q;
  logic        pendT2_d;
  logic        req_q;
  logic        req_d;
  logic [2:0]  vec_q;
  logic [2:0]  vec_d;
  logic [4:0]  win_q;
  logic [4:0]  win_d;
  logic [7:0]  outs_q;
  logic [7:0]  outs_d;
  logic [5:0]  srcReq;
  logic [5:0]  srcEn;
  logic        anyEnReq;
  logic        extWake;
  logic        hwReset;
  logic        sfrReset;
  logic        wrAcc;
  logic        flagWr;
  logic        ctrlWr;
  logic        mapped;

  irqen_mcycle u_mcycle (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tim     (tim)
  );

  // Two-stage synchronisers for the pins: A, B, trigger, reset.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      logic pinRaw;
      assign pinRaw = (gi == 0) ? externalIrqPinA_n :
                      (gi == 1) ? externalIrqPinB_n :
                      (gi == 2) ? timer2TriggerPin : hwResetPin;
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          sync1_q[gi]   <= (gi != 3); // Idle levels: pins high, reset low.
          sync2_q[gi]   <= (gi != 3);
          pinPrev_q[gi] <= (gi != 3);
        end
        else
        begin
          sync1_q[gi]   <= pinRaw;
          sync2_q[gi]   <= sync1_q[gi];
          pinPrev_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  // Source requests and their gating by the enable register.
  assign hwReset  = sync2_q[3];
  assign sfrReset = hwReset && (state_q == irqen_pkg::MODE_RUN ||
                                state_q == irqen_pkg::MODE_PWRDN);
  assign srcReq   = {flags_q[5] | flags_q[irqen_pkg::IRQEN_FL_T2PIN],
                     serialReq, flags_q[3:0]};
  assign srcEn    = enable_q[irqen_pkg::IRQEN_EN_GLOBAL] ?
                    enable_q[5:0] : 6'h00;
  assign anyEnReq = |(srcReq & srcEn);
  assign extWake  = (srcEn[irqen_pkg::IRQEN_EN_EXTA] && !sync2_q[0]) ||
                    (srcEn[irqen_pkg::IRQEN_EN_EXTB] && !sync2_q[1]);

  // APB decode; every access completes in its first access cycle.
  assign wrAcc   = psel && penable && pwrite;
  assign mapped  = (paddr == irqen_pkg::IRQEN_OFF_ENABLE) ||
                   (paddr == irqen_pkg::IRQEN_OFF_FLAGS)  ||
                   (paddr == irqen_pkg::IRQEN_OFF_CTRL)   ||
                   (paddr == irqen_pkg::IRQEN_OFF_STATUS);
  assign flagWr  = wrAcc && (paddr == irqen_pkg::IRQEN_OFF_FLAGS);
  assign ctrlWr  = wrAcc && (paddr == irqen_pkg::IRQEN_OFF_CTRL);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read multiplexer; reserved bits read as zero.
  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      irqen_pkg::IRQEN_OFF_ENABLE: prdata[7:0] = enable_q;
      irqen_pkg::IRQEN_OFF_FLAGS:  prdata[6:0] = {flags_q[6:5], serialReq,
                                                  flags_q[3:0]};
      irqen_pkg::IRQEN_OFF_CTRL:   prdata[3:0] = ctrl_q;
      irqen_pkg::IRQEN_OFF_STATUS: prdata[5:0] = {vec_q, req_q,
                                                  2'(state_q)};
      default:                     prdata = 32'h0000_0000;
    endcase
  end

  // Software registers and source flags; a set wins over a clear.
  always_comb
  begin
    enable_d = enable_q;
    ctrl_d   = ctrl_q;
    flags_d  = flags_q;
    pendT0_d = pendT0_q | timer0Ovf;
    pendT1_d = pendT1_q | timer1Ovf;
    pendT2_d = pendT2_q | (timer2Ovf && !ctrl_q[irqen_pkg::IRQEN_CT_BAUD]);
    if (wrAcc && paddr == irqen_pkg::IRQEN_OFF_ENABLE)
      enable_d = pwdata[7:0] & irqen_pkg::IRQEN_EN_MASK; // Bit 6 kept zero
    if (ctrlWr)
      ctrl_d = {pwdata[3:2], 2'b00};
    if (flagWr)
      flags_d = flags_q & ~(pwdata[6:0] & irqen_pkg::IRQEN_FL_MASK);
    if (coreAck && vec_q < 3'(irqen_pkg::IRQEN_EN_SERIAL))
      flags_d[vec_q] = 1'b0; // Timer 2 flags survive vectoring
    if (pinPrev_q[0] && !sync2_q[0])
      flags_d[irqen_pkg::IRQEN_EN_EXTA] = 1'b1;
    if (pinPrev_q[1] && !sync2_q[1])
      flags_d[irqen_pkg::IRQEN_EN_EXTB] = 1'b1;
    if (pinPrev_q[2] && !sync2_q[2] && ctrl_q[irqen_pkg::IRQEN_CT_TRIG])
      flags_d[irqen_pkg::IRQEN_FL_T2PIN] = 1'b1;
    if (tim.state5Phase2)
    begin
      flags_d[irqen_pkg::IRQEN_EN_T0] = flags_d[1] | pendT0_d;
      flags_d[irqen_pkg::IRQEN_EN_T1] = flags_d[3] | pendT1_d;
      pendT0_d = 1'b0;
      pendT1_d = 1'b0;
    end
    if (tim.state2Phase2)
    begin
      flags_d[5] = flags_d[5] | (pendT2_d &&
                   !ctrl_q[irqen_pkg::IRQEN_CT_BAUD]);
      pendT2_d   = 1'b0;
    end
  end

  // Registers of the software-visible group; held across idle/power-down.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || sfrReset)
    begin
      enable_q <= irqen_pkg::IRQEN_EN_RESET;
      ctrl_q   <= 4'h0;
      flags_q  <= 7'h00;
      pendT0_q <= 1'b0;
      pendT1_q <= 1'b0;
      pendT2_q <= 1'b0;
    end
    else
    begin
      enable_q <= enable_d;
      ctrl_q   <= ctrl_d;
      flags_q  <= flags_d;
      pendT0_q <= pendT0_d;
      pendT1_q <= pendT1_d;
      pendT2_q <= pendT2_d;
    end
  end

  // Polls enabled requests at state 5 phase 2; lowest index is served.
  always_comb
  begin
    req_d = req_q;
    vec_d = vec_q;
    if (tim.state5Phase2)
    begin
      req_d = anyEnReq;
      vec_d = 3'h0;
      for (int i = 5; i >= 0; i--)
        if (srcReq[i] && srcEn[i])
          vec_d = 3'(i);
    end
  end

  // Power mode sequencer with the reset window after idle.
  always_comb
  begin
    state_d = state_q;
    win_d   = 5'h00;
    unique case (state_q)
      irqen_pkg::MODE_RUN:
        if (ctrlWr && pwdata[irqen_pkg::IRQEN_CT_PD])
          state_d = irqen_pkg::MODE_PWRDN;
        else if (ctrlWr && pwdata[irqen_pkg::IRQEN_CT_IDLE])
          state_d = irqen_pkg::MODE_IDLE;
      irqen_pkg::MODE_IDLE:
        if (hwReset)
          state_d = irqen_pkg::MODE_RSTWIN;
        else if (anyEnReq)
          state_d = irqen_pkg::MODE_RUN;
      irqen_pkg::MODE_PWRDN:
        if (hwReset || extWake)
          state_d = irqen_pkg::MODE_RUN;
      irqen_pkg::MODE_RSTWIN:
      begin
        win_d = win_q + 5'h01;
        if (win_q == irqen_pkg::IRQEN_RST_WIN_LAST)
          state_d = irqen_pkg::MODE_RUN;
      end
    endcase
  end

  // Registered pin-side outputs, decoded from the next mode.
  always_comb
  begin
    outs_d[0] = state_d == irqen_pkg::MODE_RUN ||
                state_d == irqen_pkg::MODE_RSTWIN;
    outs_d[1] = state_d != irqen_pkg::MODE_PWRDN;
    outs_d[2] = state_d == irqen_pkg::MODE_RSTWIN;
    outs_d[3] = hwReset && (state_d == irqen_pkg::MODE_RUN ||
                            state_d == irqen_pkg::MODE_PWRDN);
    unique case (state_d)
      irqen_pkg::MODE_IDLE:  outs_d[5:4] = 2'b11;
      irqen_pkg::MODE_PWRDN: outs_d[5:4] = 2'b00;
      default:               outs_d[5:4] = {coreProgStrobe, coreAddrLatch};
    endcase
    outs_d[6] = extProgMem && (state_d == irqen_pkg::MODE_IDLE ||
                               state_d == irqen_pkg::MODE_PWRDN);
    outs_d[7] = extProgMem && state_d == irqen_pkg::MODE_IDLE;
  end

  // Registers the poll, mode and output groups.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q <= irqen_pkg::MODE_RUN;
      win_q   <= 5'h00;
      req_q   <= 1'b0;
      vec_q   <= 3'h0;
      outs_q  <= 8'h03;
    end
    else
    begin
      state_q <= state_d;
      win_q   <= win_d;
      req_q   <= req_d;
      vec_q   <= vec_d;
      outs_q  <= outs_d;
    end
  end

  // The request is re-gated so a cleared enable withdraws it at once.
  assign irqRequest      = req_q && srcEn[vec_q];
  assign irqVector       = vec_q;
  assign coreRun         = outs_q[0];
  assign oscRun          = outs_q[1];
  assign ramBlock        = outs_q[2];
  assign coreResetOut    = outs_q[3];
  assign addrLatchStrobe = outs_q[4];
  assign progStoreStrobe = outs_q[5];
  assign port0Float      = outs_q[6];
  assign port2AddrDrive  = outs_q[7];

  a_global_gate_off: assert property (@(posedge clk_sys)
    disable iff (!rst_n) !enable_q[irqen_pkg::IRQEN_EN_GLOBAL] |->
    !irqRequest)
    else $error("Request raised with global enable clear.");
  a_source_enable_held: assert property (@(posedge clk_sys)
    disable iff (!rst_n) irqRequest |-> enable_q[irqen_pkg::IRQEN_EN_GLOBAL]
    && enable_q[vec_q] && (!$rose(irqRequest) || srcReq[vec_q]))
    else $error("Request for a disabled or idle source.");
  a_t2_flag_kept: assert property (@(posedge clk_sys)
    disable iff (!rst_n) coreAck && flags_q[5] && !flagWr && !sfrReset |=>
    flags_q[5])
    else $error("Timer 2 flag cleared by vectoring.");
  a_t01_set_phase: assert property (@(posedge clk_sys)
    disable iff (!rst_n) $rose(flags_q[1]) || $rose(flags_q[3]) |->
    $past(tim.state5Phase2))
    else $error("Timer 0/1 flag set off state 5 phase 2.");
  a_t2_set_phase: assert property (@(posedge clk_sys)
    disable iff (!rst_n) $rose(flags_q[5]) |-> $past(tim.state2Phase2)
    && !$past(ctrl_q[irqen_pkg::IRQEN_CT_BAUD]))
    else $error("Timer 2 flag set off phase or in baud mode.");
  a_idle_wake_irq: assert property (@(posedge clk_sys)
    disable iff (!rst_n) state_q == irqen_pkg::MODE_IDLE && anyEnReq &&
    !hwReset |=> state_q == irqen_pkg::MODE_RUN ##1 coreRun)
    else $error("Idle not left on enabled request.");
  a_reset_window: assert property (@(posedge clk_sys)
    disable iff (!rst_n) $rose(state_q == irqen_pkg::MODE_RSTWIN) |->
    ##1 (ramBlock && coreRun) ##[1:24] state_q == irqen_pkg::MODE_RUN)
    else $error("Reset window too long or RAM not blocked.");
  a_mode_strobes: assert property (@(posedge clk_sys)
    disable iff (!rst_n) state_q == irqen_pkg::MODE_PWRDN |=>
    state_q != irqen_pkg::MODE_PWRDN ||
    (!oscRun && !addrLatchStrobe && !progStoreStrobe))
    else $error("Power-down outputs wrong.");

endmodule : irqen_ctrl

// File: pkg/irqen_pkg.sv
// Purpose: Constants and types for the interrupt enable and wake block.
// Assumes: APB slave with 32-bit data; one clock, clk_sys at 200 MHz.
// Notes:   Offsets are byte addresses; flags and enables share bit order.
package irqen_pkg;

  // Register byte offsets.
  localparam logic [7:0] IRQEN_OFF_ENABLE = 8'h00;
  localparam logic [7:0] IRQEN_OFF_FLAGS  = 8'h04;
  localparam logic [7:0] IRQEN_OFF_CTRL   = 8'h08;
  localparam logic [7:0] IRQEN_OFF_STATUS = 8'h0C;

  // Enable register fields; source index equals its enable bit.
  localparam int IRQEN_EN_EXTA   = 0;
  localparam int IRQEN_EN_T0     = 1;
  localparam int IRQEN_EN_EXTB   = 2;
  localparam int IRQEN_EN_T1     = 3;
  localparam int IRQEN_EN_SERIAL = 4;
  localparam int IRQEN_EN_T2     = 5;
  localparam int IRQEN_EN_GLOBAL = 7;
  localparam logic [7:0] IRQEN_EN_MASK  = 8'hBF;
  localparam logic [7:0] IRQEN_EN_RESET = 8'h00;

  // Flag register fields.
  localparam int IRQEN_FL_T2PIN = 6;
  localparam logic [6:0] IRQEN_FL_MASK = 7'h6F;

  // Control register fields.
  localparam int IRQEN_CT_IDLE = 0;
  localparam int IRQEN_CT_PD   = 1;
  localparam int IRQEN_CT_TRIG = 2;
  localparam int IRQEN_CT_BAUD = 3;

  // Status register fields.
  localparam int IRQEN_ST_REQ = 2;
  localparam int IRQEN_ST_VEC = 3;

  // Machine cycle timing: twelve clocks, six states of two phases.
  localparam int unsigned IRQEN_CLK_PER_MC = 12;
  localparam logic [3:0] IRQEN_CNT_LAST = 4'hB;
  localparam logic [3:0] IRQEN_CNT_STATE2_PHASE2 = 4'h3;
  localparam logic [3:0] IRQEN_CNT_STATE5_PHASE2 = 4'h9;
  localparam int unsigned IRQEN_RST_WIN_MC = 2;
  localparam logic [4:0] IRQEN_RST_WIN_LAST =
    5'(IRQEN_RST_WIN_MC * IRQEN_CLK_PER_MC - 1);

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_PWRDN,
    MODE_RSTWIN
  } irqen_mode_t;

endpackage : irqen_pkg

// File: pkg/irqen_timing_if.sv
// Purpose: Carries machine cycle timing strobes between block modules.
// Assumes: Strobes are one clk_sys cycle wide.
// Notes:   Generator drives, the controller only reads.
`timescale 1ns/100ps
interface irqen_timing_if;
  logic state2Phase2;
  logic state5Phase2;

  modport gen (output state2Phase2, output state5Phase2);
  modport use_side (input state2Phase2, input state5Phase2);
endinterface : irqen_timing_if

// File: rtl/irqen_mcycle.sv
// Purpose: Machine cycle sequencer producing state/phase strobes.
// Assumes: Twelve clk_sys cycles per machine cycle.
// Notes:   Strobes are registered and mark the named state and phase.
`timescale 1ns/100ps
module irqen_mcycle (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  irqen_timing_if.gen tim
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       state2_phase2_q;
  logic       state2_phase2_d;
  logic       state5_phase2_q;
  logic       state5_phase2_d;

  // Counts clocks within a machine cycle and decodes the two strobes.
  always_comb
  begin
    cnt_d  = (cnt_q == irqen_pkg::IRQEN_CNT_LAST) ? 4'h0 : cnt_q + 4'h1;
    state2_phase2_d = (cnt_d == irqen_pkg::IRQEN_CNT_STATE2_PHASE2);
    state5_phase2_d = (cnt_d == irqen_pkg::IRQEN_CNT_STATE5_PHASE2);
  end

  // Registers the sequencer.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_q  <= 4'h0;
      state2_phase2_q <= 1'b0;
      state5_phase2_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      state2_phase2_q <= state2_phase2_d;
      state5_phase2_q <= state5_phase2_d;
    end
  end

  assign tim.state2Phase2 = state2_phase2_q;
  assign tim.state5Phase2 = state5_phase2_q;

endmodule : irqen_mcycle

// File: verification/irqen_core_model.sv
// Purpose: Behavioural processor core on the far side of the block.
// Assumes: One clock; a request is vectored only while the core runs.
// Notes:   One acknowledge per request, after a chosen delay.
`timescale 1ns/100ps
module irqen_core_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ackOn,
  input  wire logic [3:0] ackDelay,
  input  wire logic       irqRequest,
  input  wire logic [2:0] irqVector,
  input  wire logic       coreRun,
  output logic            coreAck,
  output logic            coreAddrLatch,
  output logic            coreProgStrobe,
  output logic      [2:0] lastVector
);
  logic       armed;
  logic [3:0] waitCnt;

  // Strobes toggle while running, so a level held in sleep stands out.
  always_ff @(posedge clk_sys)
  begin
    coreAddrLatch  <= rst_n & ~coreAddrLatch;
    coreProgStrobe <= rst_n & coreAddrLatch;
  end

  // Acknowledge once per request, prompt or slow, rearm on release.
  always_ff @(posedge clk_sys)
  begin
    coreAck <= 1'b0;
    if (!rst_n || !irqRequest)
    begin
      armed   <= 1'b1;
      waitCnt <= 4'h0;
    end
    else if (armed && coreRun && ackOn)
    begin
      if (waitCnt == ackDelay)
      begin
        coreAck    <= 1'b1;
        lastVector <= irqVector;
        armed      <= 1'b0;
      end
      else
        waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : irqen_core_model

// File: verification/tb.sv
// Purpose: Self-checking bench for interrupt gating and sleep control.
// Assumes: APB slave answers in the first access cycle or later.
// Notes:   Poll timing is judged against the machine cycle phase.
`timescale 1ns/100ps
module tb;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        pinA_n, pinB_n, trigPin, hwReset, t0, t1, t2, ser, extMem;
  logic        ack, ale, pse, irq, run, osc, ramBlk, rstOut, errSeen;
  logic        aleOut, pseOut, p0Float, p2Drive, ackOn, rstSeen;
  logic [3:0]  ackDly;
  logic [2:0]  vec, lastVec;
  int          n_fail, cmp_count, n, i;

  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Block under test and the core that services it.
  irqen_ctrl dut_u (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .externalIrqPinA_n(pinA_n),
    .externalIrqPinB_n(pinB_n), .timer2TriggerPin(trigPin),
    .hwResetPin(hwReset), .timer0Ovf(t0), .timer1Ovf(t1), .timer2Ovf(t2),
    .serialReq(ser), .extProgMem(extMem), .coreAck(ack),
    .coreAddrLatch(ale), .coreProgStrobe(pse), .irqRequest(irq),
    .irqVector(vec), .coreRun(run), .oscRun(osc), .ramBlock(ramBlk),
    .coreResetOut(rstOut), .addrLatchStrobe(aleOut),
    .progStoreStrobe(pseOut), .port0Float(p0Float), .port2AddrDrive(p2Drive)
  );
  irqen_core_model core_u (
    .clk_sys, .rst_n, .ackOn, .ackDelay(ackDly), .irqRequest(irq),
    .irqVector(vec), .coreRun(run), .coreAck(ack), .coreAddrLatch(ale),
    .coreProgStrobe(pse), .lastVector(lastVec)
  );

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // One APB transfer: setup, then access until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      n_fail++;
      test_done();
    end
    rd = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write, and register read with comparison.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string what);
    apb(1'b0, a, 32'h0, rdv);
    chk(what, e, rdv);
  endtask : rdc

  // Waits, with a bound, until request, run or oscillator takes a level.
  task automatic waitFor(input int s, input logic v, output int c);
    logic cur;
    c = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      c++;
      cur = (s == 0) ? irq : (s == 1) ? run : osc;
    end
    while (cur !== v && c < 60);
    if (cur !== v)
    begin
      n_fail++;
      $display("wrong value wait %0d expected %b seen %b", s, v, cur);
      test_done();
    end
  endtask : waitFor

  // Raises one source: pins fall for a while, timers pulse once.
  task automatic fire(input int s);
    @(posedge clk_sys);
    case (s)
      0: pinA_n <= 1'b0;
      1: t0 <= 1'b1;
      2: pinB_n <= 1'b0;
      3: t1 <= 1'b1;
      4: ser <= 1'b1;
      default: t2 <= 1'b1;
    endcase
    @(posedge clk_sys);
    t0 <= 1'b0;
    t1 <= 1'b0;
    t2 <= 1'b0;
    repeat (4) @(posedge clk_sys);
    pinA_n <= 1'b1;
    pinB_n <= 1'b1;
  endtask : fire

  // Lets the core model acknowledge, or stops it.
  task automatic setAck(input logic v);
    @(posedge clk_sys);
    ackOn <= v;
  endtask : setAck

  // Holds the reset pin for 30 cycles and counts RAM-blocked cycles.
  task automatic hwRst(output int c);
    c = 0;
    rstSeen = 1'b0;
    @(posedge clk_sys);
    hwReset <= 1'b1;
    for (int k = 0; k < 45; k++)
    begin
      @(posedge clk_sys);
      c += (ramBlk === 1'b1) ? 1 : 0;
      rstSeen |= (rstOut === 1'b1);
      if (k == 29)
        hwReset <= 1'b0;
    end
  endtask : hwRst

  // Test sequence.
  initial
  begin
    {psel, penable, pwrite, t0, t1, t2, ser, hwReset, ackOn} = 9'h0;
    {pinA_n, pinB_n, trigPin, extMem} = 4'hF;
    paddr = 8'h00;
    pwdata = 32'h0;
    ackDly = 4'h0;
    rst_n = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++)
      rdc(8'(4 * i), 32'h0, "reset value");
    apb(1'b0, 8'h10, 32'h0, rdv);
    chk("unmapped error", 32'h1, 32'(errSeen));
    chk("unmapped data", 32'h0, rdv);
    wr(8'h00, 32'hBF);
    rdc(8'h00, 32'hBF, "enable readback");
    wr(8'h00, 32'h01);
    fire(0);
    repeat (30) @(posedge clk_sys);
    chk("masked request", 32'h0, 32'(irq));
    wr(8'h00, 32'h81);
    waitFor(0, 1'b1, n);
    setAck(1'b1);
    waitFor(0, 1'b0, n);
    $display("test registers and global enable done");
    for (i = 0; i < 6; i++)
    begin
      setAck(1'b0);
      ackDly <= 4'(i);
      wr(8'h00, 32'h80 | (32'h1 << i));
      repeat (9) @(posedge clk_sys);
      fire(i);
      waitFor(0, 1'b1, n);
      chk("vector", 32'(i), 32'(vec));
      if (i == 1 || i == 3)
        chk("t0 t1 poll", 32'h1, 32'(n > 12 && n < 22));
      if (i == 5)
        chk("t2 poll", 32'h1, 32'(n > 1 && n < 10));
      rdc(8'h04, 32'h1 << i, "flag pending");
      setAck(1'b1);
      if (i >= 4)
      begin
        repeat (12) @(posedge clk_sys);
        rdc(8'h04, 32'h1 << i, "flag kept");
        ser <= 1'b0;
        wr(8'h04, 32'h60);
      end
      waitFor(0, 1'b0, n);
      chk("core vector", 32'(i), 32'(lastVec));
    end
    $display("test sources done");
    setAck(1'b0);
    ackDly <= 4'hA;
    wr(8'h00, 32'h84);
    wr(8'h08, 32'h01);
    repeat (3) @(posedge clk_sys);
    chk("idle pins", 32'h2F,
        {26'h0, osc, run, aleOut, pseOut, p0Float, p2Drive});
    rdc(8'h00, 32'h84, "enable in idle");
    apb(1'b0, 8'h0C, 32'h0, rdv);
    chk("idle mode", 32'h1, 32'(rdv[1:0]));
    setAck(1'b1);
    fire(2);
    waitFor(1, 1'b1, n);
    waitFor(0, 1'b1, n);
    waitFor(0, 1'b0, n);
    chk("wake vector", 32'h2, 32'(lastVec));
    $display("test idle done");
    setAck(1'b0);
    wr(8'h00, 32'h86);
    wr(8'h08, 32'h03);
    repeat (3) @(posedge clk_sys);
    chk("sleep pins", 32'h02,
        {26'h0, osc, run, aleOut, pseOut, p0Float, p2Drive});
    fire(1);
    repeat (30) @(posedge clk_sys);
    chk("timer no wake", 32'h0, 32'(osc));
    rdc(8'h00, 32'h86, "enable kept");
    fire(2);
    waitFor(2, 1'b1, n);
    wr(8'h08, 32'h02);
    hwRst(n);
    chk("reset wakes", 32'h1, 32'(osc));
    rdc(8'h00, 32'h0, "enable after reset");
    $display("test power-down done");
    wr(8'h00, 32'h81);
    wr(8'h08, 32'h01);
    hwRst(n);
    chk("blocked cycles", 32'h18, 32'(n));
    chk("reset follows", 32'h1, 32'(rstSeen));
    rdc(8'h00, 32'h0, "enable reset");
    $display("test idle reset done");
    wr(8'h08, 32'h0C);
    wr(8'h00, 32'hA0);
    fire(5);
    repeat (30) @(posedge clk_sys);
    rdc(8'h04, 32'h0, "baud overflow");
    @(posedge clk_sys);
    trigPin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    trigPin <= 1'b1;
    waitFor(0, 1'b1, n);
    rdc(8'h04, 32'h40, "pin event flag");
    chk("t2 vector", 32'h5, 32'(vec));
    wr(8'h00, 32'h20);
    #1;
    chk("global off", 32'h0, 32'(irq));
    $display("test timer 2 events done");
    test_done();
  end
endmodule : tb
